//--- tafq_top.sv
// thermostat alarm logic: conversion capture, limit compare, fault queue, alert
// Notes on behaviour
// - while powered up conversions run back to back, each result refreshes temperature
// - two resolution bits pick 9, 10, 11 or 12 result bits
// - resolution defaults to nine bits after reset
// - every stored result is compared with both upper and lower limit
// - alert is active low by default; polarity bit one makes it active high
// - mode bit picks comparator or interrupt; comparator after reset
// - fault when result is at or above upper, or at or below lower limit
// - two queue bits need 1, 2, 4 or 6 consecutive faults
// - counter increments per fault then is compared with queue setting
// - a conversion without any fault clears the counter
// - comparator: assert on upper valid fault, deassert on lower valid fault
// - comparator: reads, writes and power-down leave alert unchanged
// - interrupt to comparator while active keeps alert until lower valid fault
// - general call reset clears alert and restores default configuration
// - interrupt: alert holds until register read, alert response or power-down
// - interrupt: activations alternate between upper and lower valid faults
// - interrupt: first activation must come from the upper limit
// - comparator to interrupt while active keeps alert until a clear event
// - power-down entry or exit leaves the fault counter untouched
`timescale 1ns/10ps
`default_nettype none
module tafq_top (
   // system clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // conversion clock domain
   input wire logic conv_clk_i,
   output logic adc_start_o,
   input wire logic adc_done_i,
   input wire logic [tafq_pkg::ADC_W-1:0] adc_data_i,
   // configuration write
   input wire logic cfg_wr_i,
   input wire logic alarm_polarity_bit_i,
   input wire logic thermostat_mode_bit_i,
   input wire logic fault_queue_bit_hi_i,
   input wire logic fault_queue_bit_lo_i,
   input wire logic resolution_bit_hi_i,
   input wire logic resolution_bit_lo_i,
   input wire logic power_down_bit_i,
   // limits
   input wire logic [tafq_pkg::TEMP_W-1:0] limit_high_i,
   input wire logic [tafq_pkg::TEMP_W-1:0] limit_low_i,
   // serial interface events
   input wire logic reg_read_i,
   input wire logic ara_ack_i,
   input wire logic gc_reset_i,
   // status
   output logic [tafq_pkg::TEMP_W-1:0] temp_o,
   output logic temp_upd_o,
   output logic alarm_polarity_bit_o,
   output logic thermostat_mode_bit_o,
   output logic fault_queue_bit_hi_o,
   output logic fault_queue_bit_lo_o,
   output logic resolution_bit_hi_o,
   output logic resolution_bit_lo_o,
   output logic power_down_bit_o,
   output logic [tafq_pkg::CNT_W-1:0] fault_count_o,
   // alert pin
   output logic alert_o
);
   // ***************
   // configuration register
   // ***************
   logic cfg_pol_r;
   logic cfg_mode_r;
   logic cfg_pd_r;
   logic [1:0] cfg_fq_r;
   logic [1:0] cfg_res_r;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_pol_r <= tafq_pkg::DEF_POL;
         cfg_mode_r <= tafq_pkg::MODE_CMP;
         cfg_pd_r <= tafq_pkg::DEF_PD;
         cfg_fq_r <= tafq_pkg::DEF_FQ;
         cfg_res_r <= tafq_pkg::DEF_RES;
      end else if (gc_reset_i) begin
         cfg_pol_r <= tafq_pkg::DEF_POL;
         cfg_mode_r <= tafq_pkg::MODE_CMP;
         cfg_pd_r <= tafq_pkg::DEF_PD;
         cfg_fq_r <= tafq_pkg::DEF_FQ;
         cfg_res_r <= tafq_pkg::DEF_RES;
      end else if (cfg_wr_i) begin
         cfg_pol_r <= alarm_polarity_bit_i;
         cfg_mode_r <= thermostat_mode_bit_i;
         cfg_pd_r <= power_down_bit_i;
         cfg_fq_r <= {fault_queue_bit_hi_i, fault_queue_bit_lo_i};
         cfg_res_r <= {resolution_bit_hi_i, resolution_bit_lo_i};
      end
   end
   assign alarm_polarity_bit_o = cfg_pol_r;
   assign thermostat_mode_bit_o = cfg_mode_r;
   assign power_down_bit_o = cfg_pd_r;
   assign fault_queue_bit_hi_o = cfg_fq_r[1];
   assign fault_queue_bit_lo_o = cfg_fq_r[0];
   assign resolution_bit_hi_o = cfg_res_r[1];
   assign resolution_bit_lo_o = cfg_res_r[0];

   // ***************
   // conversion domain
   // ***************
   tafq_pkg::tafq_conv_e cv_state_r;
   tafq_pkg::tafq_conv_e cv_state_nxt;
   logic cv_req_tgl_r;
   logic [tafq_pkg::ADC_W-1:0] cv_data_r;
   logic cv_pd;
   logic cv_ack_chg;
   tafq_sync u_pd_sync (
      .clk_i(conv_clk_i),
      .rst_b_i(rst_b_i),
      .d_i(cfg_pd_r),
      .q_o(cv_pd),
      .chg_o()
   );
   logic ack_tgl_r;
   tafq_sync u_ack_sync (
      .clk_i(conv_clk_i),
      .rst_b_i(rst_b_i),
      .d_i(ack_tgl_r),
      .q_o(),
      .chg_o(cv_ack_chg)
   );
   // result held until the system side acknowledges, so the word is stable when taken
   always_comb begin
      cv_state_nxt = cv_state_r;
      case (cv_state_r)
         tafq_pkg::TAFQ_IDLE: begin
            if (!cv_pd) begin
               cv_state_nxt = tafq_pkg::TAFQ_CONV;
            end
         end
         tafq_pkg::TAFQ_CONV: begin
            if (adc_done_i) begin
               cv_state_nxt = tafq_pkg::TAFQ_HOLD;
            end
         end
         tafq_pkg::TAFQ_HOLD: begin
            if (cv_ack_chg) begin
               cv_state_nxt = tafq_pkg::TAFQ_IDLE;
            end
         end
         default: begin
            cv_state_nxt = tafq_pkg::TAFQ_IDLE;
         end
      endcase
   end
   always_ff @(posedge conv_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cv_state_r <= tafq_pkg::TAFQ_IDLE;
         cv_req_tgl_r <= 1'b0;
         cv_data_r <= '0;
      end else begin
         cv_state_r <= cv_state_nxt;
         if (cv_state_r == tafq_pkg::TAFQ_CONV && adc_done_i) begin
            cv_data_r <= adc_data_i;
            cv_req_tgl_r <= ~cv_req_tgl_r;
         end
      end
   end
   assign adc_start_o = (cv_state_r == tafq_pkg::TAFQ_IDLE) && !cv_pd;

   // ***************
   // result capture
   // ***************
   logic req_chg;
   tafq_sync u_req_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .d_i(cv_req_tgl_r),
      .q_o(),
      .chg_o(req_chg)
   );
   logic [tafq_pkg::TEMP_W-1:0] temp_r;
   logic sample_r;
   wire [tafq_pkg::TEMP_W-1:0] raw_w = {cv_data_r, {tafq_pkg::TEMP_LSB{1'b0}}};
   wire [tafq_pkg::TEMP_W-1:0] temp_nxt = raw_w & tafq_pkg::res_mask(cfg_res_r);
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         temp_r <= '0;
         sample_r <= 1'b0;
         ack_tgl_r <= 1'b0;
      end else begin
         sample_r <= req_chg;
         if (req_chg) begin
            temp_r <= temp_nxt;
            ack_tgl_r <= ~ack_tgl_r;
         end
      end
   end
   assign temp_o = temp_r;
   assign temp_upd_o = sample_r;

   // ***************
   // limit compare and fault queue
   // ***************
   // upper must exceed lower; with overlap both flags set and high wins
   wire hi_w = $signed(temp_r) >= $signed(limit_high_i);
   wire lo_w = $signed(temp_r) <= $signed(limit_low_i);
   logic valid_hi;
   logic valid_lo;
   logic [tafq_pkg::CNT_W-1:0] depth_w;
   assign depth_w = tafq_pkg::queue_depth(cfg_fq_r);
   tafq_fault_queue u_fq (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .clear_i(gc_reset_i),
      .sample_i(sample_r),
      .hi_i(hi_w),
      .lo_i(lo_w),
      .depth_i(depth_w),
      .valid_hi_o(valid_hi),
      .valid_lo_o(valid_lo),
      .count_o(fault_count_o)
   );

   // ***************
   // alert state
   // ***************
   logic alarm_r;
   logic expect_hi_r;
   logic pd_d_r;
   logic alert_r;
   wire int_mode = cfg_mode_r == tafq_pkg::MODE_INT;
   wire pd_rise = cfg_pd_r & ~pd_d_r;
   wire int_clr = int_mode & (reg_read_i | ara_ack_i | pd_rise);
   wire int_set = int_mode & (expect_hi_r ? valid_hi : valid_lo);
   wire cmp_set = ~int_mode & valid_hi;
   wire cmp_clr = ~int_mode & valid_lo;
   // a set wins over a clear in the same cycle; a general call reset wins over both
   wire alarm_nxt = gc_reset_i ? 1'b0 : ((int_set | cmp_set) ? 1'b1 :
                    ((int_clr | cmp_clr) ? 1'b0 : alarm_r));
   wire pol_nxt = gc_reset_i ? tafq_pkg::DEF_POL : (cfg_wr_i ? alarm_polarity_bit_i : cfg_pol_r);
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         alarm_r <= 1'b0;
         expect_hi_r <= 1'b1;
         pd_d_r <= 1'b0;
         alert_r <= 1'b1;
      end else begin
         alarm_r <= alarm_nxt;
         pd_d_r <= cfg_pd_r;
         alert_r <= pol_nxt ? alarm_nxt : ~alarm_nxt;
         if (gc_reset_i) begin
            expect_hi_r <= 1'b1;
         end else if (int_set) begin
            expect_hi_r <= ~expect_hi_r;
         end
      end
   end
   assign alert_o = alert_r;

   // ***************
   // checks
   // ***************
   AST_RES_DEFAULT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      gc_reset_i |=> cfg_res_r == tafq_pkg::RES_9 && !cfg_mode_r)
      else $error("resolution or mode not restored by general call");
   AST_GC_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      gc_reset_i |=> !alarm_r ##1 alert_o == !cfg_pol_r)
      else $error("general call did not clear the alert");
   AST_POLARITY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      alarm_r |-> alert_o == cfg_pol_r)
      else $error("alert level disagrees with polarity");
   AST_CAPTURE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      req_chg |=> temp_upd_o && temp_o == $past(temp_nxt))
      else $error("temperature not refreshed after conversion");
   AST_NO_FAULT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sample_r && !hi_w && !lo_w && !gc_reset_i |=> fault_count_o == '0)
      else $error("fault counter not cleared");
   AST_VALID_COUNT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (valid_hi || valid_lo) && !gc_reset_i |=> fault_count_o == depth_w)
      else $error("valid fault without queue depth reached");
   AST_SATURATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !cfg_wr_i |=> fault_count_o <= depth_w)
      else $error("fault counter passed queue depth");
   AST_CMP_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !int_mode && valid_hi && !gc_reset_i |=> alarm_r)
      else $error("comparator alert missing on upper fault");
   AST_CMP_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !int_mode && !valid_hi && !valid_lo && !gc_reset_i |=> $stable(alarm_r))
      else $error("comparator alert moved without valid fault");
   AST_INT_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      int_mode && (reg_read_i || ara_ack_i) && !int_set |=> !alarm_r)
      else $error("interrupt alert not cleared by read or response");
   AST_INT_FIRST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      int_mode && expect_hi_r && !valid_hi && !alarm_r && !cfg_wr_i |=> !alarm_r)
      else $error("interrupt alert raised by a lower fault first");
   AST_PD_COUNT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pd_rise && !sample_r && !gc_reset_i |=> $stable(fault_count_o))
      else $error("power-down changed the fault counter");
   AST_CONV_LOOP: assert property (@(posedge conv_clk_i) disable iff (!rst_b_i)
      cv_state_r == tafq_pkg::TAFQ_HOLD && cv_ack_chg |=> cv_state_r == tafq_pkg::TAFQ_IDLE)
      else $error("conversion loop stalled after acknowledge");
endmodule
`default_nettype wire

//--- tafq_pkg.sv
// shared constants and types for the thermal alarm fault queue
package tafq_pkg;
   // ***************
   // widths
   // ***************
   localparam int ADC_W = 12;
   localparam int TEMP_W = 16;
   localparam int TEMP_LSB = 4;
   localparam int CNT_W = 3;
   // ***************
   // resolution codes and masks
   // ***************
   localparam logic [1:0] RES_9 = 2'h0;
   localparam logic [1:0] RES_10 = 2'h1;
   localparam logic [1:0] RES_11 = 2'h2;
   localparam logic [15:0] MASK_9 = 16'hFF80;
   localparam logic [15:0] MASK_10 = 16'hFFC0;
   localparam logic [15:0] MASK_11 = 16'hFFE0;
   localparam logic [15:0] MASK_12 = 16'hFFF0;
   // ***************
   // fault queue codes and depths
   // ***************
   localparam logic [1:0] FQ_1 = 2'h0;
   localparam logic [1:0] FQ_2 = 2'h1;
   localparam logic [1:0] FQ_4 = 2'h2;
   localparam logic [2:0] DEPTH_1 = 3'h1;
   localparam logic [2:0] DEPTH_2 = 3'h2;
   localparam logic [2:0] DEPTH_4 = 3'h4;
   localparam logic [2:0] DEPTH_6 = 3'h6;
   // ***************
   // configuration defaults
   // ***************
   localparam logic DEF_POL = 1'h0;
   localparam logic MODE_CMP = 1'h0;
   localparam logic MODE_INT = 1'h1;
   localparam logic DEF_PD = 1'h0;
   localparam logic [1:0] DEF_FQ = 2'h0;
   localparam logic [1:0] DEF_RES = 2'h0;
   typedef enum logic [1:0] {
      TAFQ_IDLE = 2'b00,
      TAFQ_CONV = 2'b01,
      TAFQ_HOLD = 2'b10
   } tafq_conv_e;
   function automatic logic [2:0] queue_depth(input logic [1:0] code);
      if (code == FQ_1) begin
         return DEPTH_1;
      end else if (code == FQ_2) begin
         return DEPTH_2;
      end else if (code == FQ_4) begin
         return DEPTH_4;
      end
      return DEPTH_6;
   endfunction
   function automatic logic [15:0] res_mask(input logic [1:0] code);
      if (code == RES_9) begin
         return MASK_9;
      end else if (code == RES_10) begin
         return MASK_10;
      end else if (code == RES_11) begin
         return MASK_11;
      end
      return MASK_12;
   endfunction
endpackage

//--- tafq_sync.sv
// three-stage synchroniser with difference-based change detect
`timescale 1ns/10ps
`default_nettype none
module tafq_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // level in and out
   input wire logic d_i,
   output logic q_o,
   output logic chg_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= d_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   // s1 feeds only s2; a change counts while s2 and s3 differ
   assign q_o = s3_r;
   assign chg_o = s2_r ^ s3_r;
endmodule
`default_nettype wire

//--- tafq_fault_queue.sv
// consecutive fault counter qualifying high and low limit faults
`timescale 1ns/10ps
`default_nettype none
module tafq_fault_queue (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic clear_i,
   // per-sample compare results
   input wire logic sample_i,
   input wire logic hi_i,
   input wire logic lo_i,
   input wire logic [tafq_pkg::CNT_W-1:0] depth_i,
   // qualified faults
   output logic valid_hi_o,
   output logic valid_lo_o,
   output logic [tafq_pkg::CNT_W-1:0] count_o
);
   logic [tafq_pkg::CNT_W-1:0] cnt_r;
   logic [tafq_pkg::CNT_W-1:0] cnt_nxt;
   logic last_hi_r;
   wire fault = hi_i | lo_i;
   // a change of fault side restarts the run
   wire [tafq_pkg::CNT_W-1:0] base = (hi_i != last_hi_r) ? '0 : cnt_r;
   wire [tafq_pkg::CNT_W-1:0] inc = (base >= depth_i) ? depth_i : base + 1'b1;
   assign cnt_nxt = !sample_i ? cnt_r : (fault ? inc : '0);
   wire met = sample_i & fault & (cnt_nxt == depth_i);
   assign valid_hi_o = met & hi_i;
   assign valid_lo_o = met & lo_i & ~hi_i;
   assign count_o = cnt_r;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= '0;
         last_hi_r <= 1'b0;
      end else if (clear_i) begin
         cnt_r <= '0;
         last_hi_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         if (sample_i && fault) begin
            last_hi_r <= hi_i;
         end
      end
   end
endmodule
`default_nettype wire

//--- tafq_note_fix.sv
// holds no code; the alarm logic lives in the other design files

//--- tafq_adc_model.sv
// conversion-side model: answers each start request after a set latency
`timescale 1ns/10ps
`default_nettype none
module tafq_adc_model (
   // clock and reset
   input wire logic conv_clk_i,
   input wire logic rst_b_i,
   // request and settings from the bench
   input wire logic start_i,
   input wire logic [7:0] lat_i,
   input wire logic [11:0] val_i,
   // result
   output logic done_o,
   output logic [11:0] data_o
);
   // ***************
   // converter
   // ***************
   logic busy_r;
   logic [7:0] cnt_r;
   // data toggles while not valid, so a stale word never passes for a result
   always_ff @(posedge conv_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_r <= 1'h0;
         cnt_r <= 8'h00;
         done_o <= 1'h0;
         data_o <= 12'h5A5;
      end else begin
         done_o <= 1'h0;
         data_o <= ~data_o;
         if (busy_r && cnt_r == 8'h00) begin
            done_o <= 1'h1;
            data_o <= val_i;
            busy_r <= 1'h0;
         end else if (busy_r) begin
            cnt_r <= cnt_r - 8'h01;
         end else if (start_i) begin
            busy_r <= 1'h1;
            cnt_r <= lat_i;
         end
      end
   end
endmodule
`default_nettype wire

//--- tafq_top_test.sv
// bench for the thermal alarm logic with its conversion model
`timescale 1ns/10ps
`default_nettype none
module tafq_top_test;
   // ***************
   // wiring
   // ***************
   localparam logic [11:0] HOT = 12'h510;
   localparam logic [11:0] HEQ = 12'h500;
   localparam logic [11:0] MID = 12'h4D0;
   localparam logic [11:0] COLD = 12'h4A0;
   localparam logic [11:0] LEQ = 12'h4B0;
   logic clk_i = 1'h0;
   logic conv_clk = 1'h0;
   logic rst_b = 1'h0;
   logic cfg_wr = 1'h0;
   logic [6:0] cfg_b = 7'h00;
   logic [2:0] ev = 3'h0;
   logic [7:0] lat = 8'h18;
   logic [11:0] tval = 12'h4D0;
   logic start;
   logic done;
   logic [11:0] data;
   logic [15:0] temp;
   logic upd;
   logic alert;
   wire [6:0] bits;
   logic [2:0] cnt;
   logic cur_pol = 1'h0;
   logic [1:0] cur_res = 2'h0;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   // odd offset keeps the two clocks out of step
   initial begin
      #1.3;
      forever #3 conv_clk = ~conv_clk;
   end
   tafq_adc_model adc (.conv_clk_i(conv_clk), .rst_b_i(rst_b), .start_i(start),
      .lat_i(lat), .val_i(tval), .done_o(done), .data_o(data));
   tafq_top uut (.clk_i(clk_i), .rst_b_i(rst_b), .conv_clk_i(conv_clk),
      .adc_start_o(start), .adc_done_i(done), .adc_data_i(data), .cfg_wr_i(cfg_wr),
      .alarm_polarity_bit_i(cfg_b[6]), .thermostat_mode_bit_i(cfg_b[5]),
      .fault_queue_bit_hi_i(cfg_b[4]), .fault_queue_bit_lo_i(cfg_b[3]),
      .resolution_bit_hi_i(cfg_b[2]), .resolution_bit_lo_i(cfg_b[1]),
      .power_down_bit_i(cfg_b[0]),
      .limit_high_i(16'h5000), .limit_low_i(16'h4B00),
      .reg_read_i(ev[2]), .ara_ack_i(ev[1]), .gc_reset_i(ev[0]),
      .temp_o(temp), .temp_upd_o(upd),
      .alarm_polarity_bit_o(bits[6]), .thermostat_mode_bit_o(bits[5]),
      .fault_queue_bit_hi_o(bits[4]), .fault_queue_bit_lo_o(bits[3]),
      .resolution_bit_hi_o(bits[2]), .resolution_bit_lo_o(bits[1]),
      .power_down_bit_o(bits[0]), .fault_count_o(cnt), .alert_o(alert));
   // ***************
   // helpers
   // ***************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [15:0] msk(input logic [1:0] r);
      if (r == 2'h0) return tafq_pkg::MASK_9;
      if (r == 2'h1) return tafq_pkg::MASK_10;
      if (r == 2'h2) return tafq_pkg::MASK_11;
      return tafq_pkg::MASK_12;
   endfunction
   task automatic step();
      @(posedge clk_i);
      #1;
   endtask
   task automatic chk_alert(input logic act);
      chk("alert", {15'h0, cur_pol ? act : ~act}, {15'h0, alert});
   endtask
   // caller must be within a few cycles of the last update, before the next result lands
   task automatic conv(input logic [11:0] v, input logic act, input logic [2:0] c);
      int n;
      n = 0;
      tval = v;
      do begin
         step();
         n++;
      end while (upd !== 1'b1 && n < 60);
      chk("update", 16'h1, {15'h0, upd});
      chk("temp", {v, 4'h0} & msk(cur_res), temp);
      step();
      chk_alert(act);
      chk("count", {13'h0, c}, {13'h0, cnt});
   endtask
   task automatic cfg(input logic [6:0] b);
      cfg_b = b;
      cfg_wr = 1'h1;
      step();
      cfg_wr = 1'h0;
      step();
      cur_pol = b[6];
      cur_res = b[2:1];
      chk("config", {9'h0, b}, {9'h0, bits});
   endtask
   task automatic pulse(input logic [2:0] w);
      ev = w;
      step();
      ev = 3'h0;
      step();
   endtask
   // ***************
   // scenarios
   // ***************
   task automatic t_reset();
      chk("config", 16'h0, {9'h0, bits});
      chk_alert(1'b0);
      chk("count", 16'h0, {13'h0, cnt});
      conv(MID, 1'b0, 3'h0);
      $display("reset test done");
   endtask
   task automatic t_res();
      tval = 12'h4D7;
      lat = 8'h01;
      for (int r = 0; r < 4; r++) begin
         cfg({4'h0, 2'(r), 1'b0});
         conv(12'h4D7, 1'b0, 3'h0);
      end
      lat = 8'h18;
      conv(12'h4D7, 1'b0, 3'h0);
      $display("resolution test done");
   endtask
   task automatic t_cmp();
      cfg(7'h0E);
      conv(MID, 1'b0, 3'h0);
      conv(HEQ, 1'b0, 3'h1);
      conv(HOT, 1'b1, 3'h2);
      conv(MID, 1'b1, 3'h0);
      pulse(3'h4);
      chk_alert(1'b1);
      cfg(7'h0E);
      chk_alert(1'b1);
      conv(COLD, 1'b1, 3'h1);
      conv(LEQ, 1'b0, 3'h2);
      $display("comparator test done");
   endtask
   task automatic t_sat();
      cfg(7'h1E);
      for (int i = 1; i < 8; i++) begin
         conv(HOT, i >= 6, (i > 6) ? 3'h6 : 3'(i));
      end
      cfg(7'h3E);
      chk_alert(1'b1);
      pulse(3'h2);
      chk_alert(1'b0);
      pulse(3'h1);
      cur_pol = 1'h0;
      cur_res = 2'h0;
      chk("config", 16'h0, {9'h0, bits});
      chk("count", 16'h0, {13'h0, cnt});
      conv(MID, 1'b0, 3'h0);
      $display("saturation test done");
   endtask
   task automatic t_int();
      cfg(7'h60);
      conv(COLD, 1'b0, 3'h1);
      conv(HOT, 1'b1, 3'h1);
      pulse(3'h4);
      chk_alert(1'b0);
      conv(HOT, 1'b0, 3'h1);
      conv(COLD, 1'b1, 3'h1);
      pulse(3'h2);
      chk_alert(1'b0);
      conv(HOT, 1'b1, 3'h1);
      cfg(7'h40);
      chk_alert(1'b1);
      conv(MID, 1'b1, 3'h0);
      conv(COLD, 1'b0, 3'h1);
      conv(HOT, 1'b1, 3'h1);
      pulse(3'h1);
      cur_pol = 1'h0;
      cur_res = 2'h0;
      chk_alert(1'b0);
      chk("config", 16'h0, {9'h0, bits});
      conv(MID, 1'b0, 3'h0);
      $display("interrupt test done");
   endtask
   task automatic t_pd();
      int n;
      n = 0;
      cfg(7'h28);
      conv(HOT, 1'b0, 3'h1);
      conv(HOT, 1'b1, 3'h2);
      cfg(7'h29);
      chk_alert(1'b0);
      conv(HOT, 1'b0, 3'h2);
      repeat (30) begin
         step();
         n += upd;
      end
      chk("idle updates", 16'h0, 16'(n));
      chk("count", 16'h2, {13'h0, cnt});
      cfg(7'h28);
      chk("count", 16'h2, {13'h0, cnt});
      conv(COLD, 1'b0, 3'h1);
      conv(COLD, 1'b1, 3'h2);
      $display("power-down test done");
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      #1;
      rst_b = 1'h1;
      step();
      t_reset();
      t_res();
      t_cmp();
      t_sat();
      t_int();
      t_pd();
      report_and_stop();
   end
endmodule
`default_nettype wire
